// ### design/ips_params.svh
// Offsets, field positions, reset values and counts for the power-up sequencer
`ifndef IPS_PARAMS_SVH
`define IPS_PARAMS_SVH

`define IPS_CTRL_OFS       8'h00
`define IPS_STAT_OFS       8'h04

`define IPS_CTRL_TERM_LSB  0
`define IPS_CTRL_SRINV_BIT 2
`define IPS_CTRL_DONE_BIT  3

`define IPS_STAT_PHASE_LSB 0
`define IPS_STAT_MODE_LSB  5
`define IPS_STAT_PSEL_BIT  8
`define IPS_STAT_SUP_LSB   9

`define IPS_CTRL_TERM_RST  2'h1
`define IPS_CTRL_SRINV_RST 1'h0

`define IPS_INIT_CYCLES    16

`define IPS_RESP_OKAY      2'h0
`define IPS_RESP_SLVERR    2'h2

`endif

// ### design/ips_pkg.sv
// Types shared by the power-up sequencer files
package ips_pkg;

  typedef enum logic [4:0] {
    IPS_ST_POR     = 5'h01,
    IPS_ST_INIT    = 5'h02,
    IPS_ST_CONFIG  = 5'h04,
    IPS_ST_STARTUP = 5'h08,
    IPS_ST_USER    = 5'h10
  } ips_state_t;

  typedef enum logic [1:0] {
    IPS_TERM_PULLUP   = 2'h0,
    IPS_TERM_PULLDOWN = 2'h1,
    IPS_TERM_FLOAT    = 2'h2
  } ips_term_t;

endpackage

// ### design/ips_sync3.sv
// Three-stage pin synchroniser; output follows once stages two and three agree
module ips_sync3 #(
  parameter int         WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s1_r     <= RST_VAL;
      s2_r     <= RST_VAL;
      s3_r     <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        sync_out <= s3_r;
      end
    end
  end

endmodule

// ### design/ips_sequencer.sv
// Power-on, configuration and start-up sequencer with AXI4-Lite control
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`include "ips_params.svh"

module ips_sequencer #(
  parameter int ADDR_W      = 8,
  parameter int INIT_CYCLES = `IPS_INIT_CYCLES
) (
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              vccint_ok,
  input  wire logic              vccaux_ok,
  input  wire logic              vcco_bank2_ok,
  input  wire logic              config_pullup_select,
  input  wire logic              mode_select_0,
  input  wire logic              mode_select_1,
  input  wire logic              mode_select_2,
  input  wire logic              bscan_highz_active,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   init_complete,
  output logic                   global_set_reset,
  output logic                   global_output_tristate,
  output logic                   global_write_enable,
  output logic                   io_pullup_en,
  output logic                   io_pulldown_en,
  output logic                   unused_pullup_en,
  output logic                   unused_pulldown_en,
  output logic                   select_pin_pull_en,
  output logic                   select_pin_gpio_en,
  output logic                   io_reg_level,
  output logic [2:0]             config_mode
);
  import ips_pkg::*;

  localparam int CNT_W = $clog2(INIT_CYCLES + 1);
  localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(INIT_CYCLES - 1);

  function automatic logic ofs_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] ofs);
    ofs_hit = (addr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
  endfunction

  logic [2:0]  supply_s;
  logic        psel_s;
  logic [2:0]  mode_s;
  logic        bscan_s;
  logic        power_good;
  ips_state_t  state_r;
  ips_state_t  state_nxt;
  logic [CNT_W-1:0] init_cnt_r;
  logic [2:0]  mode_r;
  ips_term_t   term_r;
  logic        srinv_r;
  logic        done_req;
  logic        aw_have_r;
  logic        w_have_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;
  logic        do_write;
  logic        ctrl_wr;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic        user_nxt;
  logic        cfg_phase_nxt;

  // Internal pull-up on the select pin: undriven reads as high
  ips_sync3 #(.WIDTH(1), .RST_VAL(1'b1)) u_sync_psel (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pin_in   (config_pullup_select),
    .sync_out (psel_s)
  );

  ips_sync3 #(.WIDTH(3), .RST_VAL(3'h0)) u_sync_sup (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pin_in   ({vcco_bank2_ok, vccaux_ok, vccint_ok}),
    .sync_out (supply_s)
  );

  ips_sync3 #(.WIDTH(3), .RST_VAL(3'h0)) u_sync_mode (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pin_in   ({mode_select_2, mode_select_1, mode_select_0}),
    .sync_out (mode_s)
  );

  ips_sync3 #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_bscan (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .pin_in   (bscan_highz_active),
    .sync_out (bscan_s)
  );

  assign power_good = &supply_s;
  assign do_write   = aw_have_r && w_have_r && !s_axi_bvalid;
  assign ctrl_wr    = do_write && ofs_hit(awaddr_r, `IPS_CTRL_OFS) && wstrb_r[0];
  assign done_req   = ctrl_wr && wdata_r[`IPS_CTRL_DONE_BIT];

  // Phase order is fixed; loss of any supply restarts from power-on
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      IPS_ST_POR: begin
        if (power_good) begin
          state_nxt = IPS_ST_INIT;
        end
      end
      IPS_ST_INIT: begin
        if (init_cnt_r == INIT_LAST) begin
          state_nxt = IPS_ST_CONFIG;
        end
      end
      IPS_ST_CONFIG: begin
        if (done_req) begin
          state_nxt = IPS_ST_STARTUP;
        end
      end
      IPS_ST_STARTUP: begin
        state_nxt = IPS_ST_USER;
      end
      IPS_ST_USER: begin
        state_nxt = IPS_ST_USER;
      end
      default: begin
        state_nxt = IPS_ST_POR;
      end
    endcase
    if (!power_good) begin
      state_nxt = IPS_ST_POR;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= IPS_ST_POR;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Memory initialisation runs as soon as the supplies are good
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      init_cnt_r <= '0;
    end else if (state_r == IPS_ST_INIT) begin
      init_cnt_r <= init_cnt_r + CNT_W'(1);
    end else begin
      init_cnt_r <= '0;
    end
  end

  // Mode captured once at the end of initialisation and then frozen
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_r <= 3'h0;
    end else if (state_r == IPS_ST_INIT && state_nxt == IPS_ST_CONFIG) begin
      mode_r <= mode_s;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      term_r  <= ips_term_t'(`IPS_CTRL_TERM_RST);
      srinv_r <= `IPS_CTRL_SRINV_RST;
    end else if (ctrl_wr) begin
      if (wdata_r[`IPS_CTRL_TERM_LSB +: 2] != 2'h3) begin
        term_r <= ips_term_t'(wdata_r[`IPS_CTRL_TERM_LSB +: 2]);
      end
      srinv_r <= wdata_r[`IPS_CTRL_SRINV_BIT];
    end
  end

  assign user_nxt      = (state_nxt == IPS_ST_STARTUP) || (state_nxt == IPS_ST_USER);
  assign cfg_phase_nxt = !user_nxt;

  // Global nets registered from the next phase, config_mode from the current phase, so each output is a flop
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      init_complete          <= 1'b0;
      global_set_reset       <= 1'b1;
      global_output_tristate <= 1'b1;
      global_write_enable    <= 1'b0;
      io_reg_level           <= 1'b0;
      config_mode            <= 3'h0;
    end else begin
      init_complete          <= (state_nxt != IPS_ST_POR) && (state_nxt != IPS_ST_INIT);
      global_set_reset       <= cfg_phase_nxt;
      global_output_tristate <= cfg_phase_nxt;
      global_write_enable    <= (state_nxt == IPS_ST_USER);
      io_reg_level           <= user_nxt ? (ctrl_wr ? wdata_r[`IPS_CTRL_SRINV_BIT] : srinv_r) : 1'b0;
      config_mode            <= (state_r == IPS_ST_INIT) ? mode_s : mode_r;
    end
  end

  // Pull control; boundary scan forces pull-downs over the I/O and unused-pin pull-ups, but not over the select pin pull
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      io_pullup_en       <= 1'b0;
      io_pulldown_en     <= 1'b0;
      unused_pullup_en   <= 1'b0;
      unused_pulldown_en <= 1'b0;
      select_pin_pull_en <= 1'b1;
      select_pin_gpio_en <= 1'b0;
    end else begin
      io_pullup_en       <= cfg_phase_nxt && !psel_s && !bscan_s;
      io_pulldown_en     <= bscan_s;
      unused_pullup_en   <= user_nxt && (term_r == IPS_TERM_PULLUP) && !bscan_s;
      unused_pulldown_en <= bscan_s || (user_nxt && (term_r == IPS_TERM_PULLDOWN));
      select_pin_pull_en <= (state_nxt != IPS_ST_USER);
      select_pin_gpio_en <= (state_nxt == IPS_ST_USER);
    end
  end

  // Write channels taken in either order; response once both are held
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_awready <= 1'b1;
      aw_have_r     <= 1'b0;
      awaddr_r      <= '0;
    end else if (s_axi_awready && s_axi_awvalid) begin
      s_axi_awready <= 1'b0;
      aw_have_r     <= 1'b1;
      awaddr_r      <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
      aw_have_r     <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_wready <= 1'b1;
      w_have_r     <= 1'b0;
      wdata_r      <= 32'h0;
      wstrb_r      <= 4'h0;
    end else if (s_axi_wready && s_axi_wvalid) begin
      s_axi_wready <= 1'b0;
      w_have_r     <= 1'b1;
      wdata_r      <= s_axi_wdata;
      wstrb_r      <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
      w_have_r     <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `IPS_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (ofs_hit(awaddr_r, `IPS_CTRL_OFS) || ofs_hit(awaddr_r, `IPS_STAT_OFS)) begin
        s_axi_bresp <= `IPS_RESP_OKAY;
      end else begin
        s_axi_bresp <= `IPS_RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_comb begin
    rd_val = 32'h0;
    rd_ok  = 1'b1;
    if (ofs_hit(s_axi_araddr, `IPS_CTRL_OFS)) begin
      rd_val[`IPS_CTRL_TERM_LSB +: 2] = term_r;
      rd_val[`IPS_CTRL_SRINV_BIT]     = srinv_r;
    end else if (ofs_hit(s_axi_araddr, `IPS_STAT_OFS)) begin
      rd_val[`IPS_STAT_PHASE_LSB +: 5] = state_r;
      rd_val[`IPS_STAT_MODE_LSB +: 3]  = mode_r;
      rd_val[`IPS_STAT_PSEL_BIT]       = psel_s;
      rd_val[`IPS_STAT_SUP_LSB +: 3]   = supply_s;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `IPS_RESP_OKAY;
    end else if (s_axi_arready && s_axi_arvalid) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_ok ? `IPS_RESP_OKAY : `IPS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ### tb/ips_props.sv
// Concurrent checks on the sequencer pins
module ips_props (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       bscan_highz_active,
  input wire logic       init_complete,
  input wire logic       global_set_reset,
  input wire logic       global_output_tristate,
  input wire logic       global_write_enable,
  input wire logic       io_pullup_en,
  input wire logic       io_pulldown_en,
  input wire logic       select_pin_pull_en,
  input wire logic       select_pin_gpio_en,
  input wire logic       io_reg_level,
  input wire logic [2:0] config_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  tristate_preconfig_a: assert property (!init_complete |-> global_output_tristate)
    else $error("drivers active before configuration");
  gwe_one_later_a: assert property ($fell(global_output_tristate) |-> !global_write_enable ##1 global_write_enable)
    else $error("write enable not one cycle after tristate release");
  release_order_a: assert property ($fell(global_output_tristate) |-> $past(init_complete))
    else $error("tristate released before configuration");
  reset_tracks_tri_a: assert property (global_set_reset == global_output_tristate)
    else $error("set-reset and tristate out of step");
  ioreg_low_a: assert property (global_set_reset |-> !io_reg_level)
    else $error("register level high under set-reset");
  mode_frozen_a: assert property (init_complete && $past(init_complete) |-> $stable(config_mode))
    else $error("sampled mode moved");
  user_pulls_a: assert property (global_write_enable |-> select_pin_gpio_en && !select_pin_pull_en && !io_pullup_en)
    else $error("user mode pull settings wrong");
  scan_pulldown_a: assert property (bscan_highz_active [*8] |-> io_pulldown_en && !io_pullup_en)
    else $error("pull-down not active in scan");
  init_entry_a: assert property ($rose(init_complete) |-> global_set_reset && global_output_tristate)
    else $error("init complete outside configuration");
endmodule

bind ips_sequencer ips_props u_props (
  .core_clk, .sys_rst, .bscan_highz_active, .init_complete, .global_set_reset,
  .global_output_tristate, .global_write_enable, .io_pullup_en, .io_pulldown_en,
  .select_pin_pull_en, .select_pin_gpio_en, .io_reg_level, .config_mode
);

// ### tb/ips_board.sv
// Board model: supplies, select pin with pull-up, mode straps
module ips_board (
  input  wire logic [2:0] pwr_en,
  input  wire logic       sel_drive,
  input  wire logic       sel_level,
  input  wire logic [2:0] mode_set,
  output logic            vccint_ok,
  output logic            vccaux_ok,
  output logic            vcco_bank2_ok,
  output logic            config_pullup_select,
  output logic            mode_select_0,
  output logic            mode_select_1,
  output logic            mode_select_2
);
  timeunit 1ns;
  timeprecision 1ns;
  assign {vcco_bank2_ok, vccaux_ok, vccint_ok} = pwr_en;
  // Released pin is pulled high, never left at last value
  assign config_pullup_select = sel_drive ? sel_level : 1'b1;
  // Straps settle before power so they are valid at init end
  assign {mode_select_2, mode_select_1, mode_select_0} = mode_set;
endmodule

// ### tb/ips_sequencer_tb.sv
// Self-checking bench for the power-up sequencer
`include "ips_params.svh"
module ips_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk, sys_rst, bscan_highz_active, sel_drive, sel_level;
  logic [2:0]  pwr_en, mode_set, config_mode;
  logic        vccint_ok, vccaux_ok, vcco_bank2_ok, config_pullup_select;
  logic        mode_select_0, mode_select_1, mode_select_2;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, seed;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r, t, eterm;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        init_complete, global_set_reset, global_output_tristate, global_write_enable;
  logic        io_pullup_en, io_pulldown_en, unused_pullup_en, unused_pulldown_en;
  logic        select_pin_pull_en, select_pin_gpio_en, io_reg_level, sr;
  int          err_count, checks_done, cyc;
  // Value 3 is ignored, so the first pass keeps the pull-down default
  localparam logic [1:0] TERMS [3] = '{2'h3, 2'h0, 2'h2};

  ips_sequencer #(.INIT_CYCLES(4)) uut (
    .core_clk, .sys_rst, .vccint_ok, .vccaux_ok, .vcco_bank2_ok, .config_pullup_select,
    .mode_select_0, .mode_select_1, .mode_select_2, .bscan_highz_active,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .init_complete,
    .global_set_reset, .global_output_tristate, .global_write_enable, .io_pullup_en, .io_pulldown_en,
    .unused_pullup_en, .unused_pulldown_en, .select_pin_pull_en, .select_pin_gpio_en, .io_reg_level,
    .config_mode
  );
  ips_board board (
    .pwr_en, .sel_drive, .sel_level, .mode_set, .vccint_ok, .vccaux_ok, .vcco_bank2_ok,
    .config_pullup_select, .mode_select_0, .mode_select_1, .mode_select_2
  );

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic [1:0] pulls(input logic [1:0] tm);
    return (tm == 2'h0) ? 2'h2 : (tm == 2'h1) ? 2'h1 : 2'h0;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rr);
    logic pa, pw, ta, tw, got;
    pa = 1'b1;
    pw = 1'b1;
    got = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!got) begin
      @(negedge core_clk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      got = !pa && !pw && s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rr);
    logic pa, ta, got;
    pa = 1'b1;
    got = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!got) begin
      @(negedge core_clk);
      ta = pa && s_axi_arready;
      got = !pa && s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      pa = pa && !ta;
    end
    s_axi_rready <= 1'b0;
  endtask

  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;
  // Whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      complete_run();
    end
  end

  initial begin
    {sys_rst, sel_drive, sel_level, seed, eterm} = {1'b1, 2'b00, 8'h3D, 2'h1};
    {pwr_en, mode_set, bscan_highz_active, cyc, err_count, checks_done} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {48'h0, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk);
    chk(global_output_tristate, 1'b1);
    chk(select_pin_pull_en, 1'b1);
    for (int it = 0; it < 3; it++) begin
      @(posedge core_clk);
      seed = lfsr(seed);
      mode_set <= seed[2:0];
      sel_drive <= seed[3];
      sel_level <= seed[4];
      // Done while powered down must be ignored; term 3 keeps the previous termination
      axw(`IPS_CTRL_OFS, 32'hB, r);
      axr(`IPS_STAT_OFS, d, r);
      chk(d[4:0], 5'h01);
      pwr_en <= 3'h7;
      for (int n = 0; n < 100 && init_complete !== 1'b1; n++) @(negedge core_clk);
      chk(init_complete, 1'b1);
      chk(config_mode, seed[2:0]);
      chk(io_pullup_en, seed[3] & ~seed[4]);
      chk(global_output_tristate, 1'b1);
      chk(global_set_reset, 1'b1);
      @(posedge core_clk);
      mode_set <= ~seed[2:0];
      repeat (8) @(negedge core_clk);
      chk(config_mode, seed[2:0]);
      chk(io_reg_level, 1'b0);
      // Scan during configuration must beat the I/O and unused-pin pull-ups
      @(posedge core_clk);
      bscan_highz_active <= 1'b1;
      repeat (9) @(negedge core_clk);
      chk({io_pulldown_en, io_pullup_en, unused_pulldown_en}, 3'h5);
      @(posedge core_clk);
      bscan_highz_active <= 1'b0;
      repeat (9) @(negedge core_clk);
      chk(io_pullup_en, seed[3] & ~seed[4]);
      t = TERMS[it];
      sr = seed[7];
      axw(`IPS_CTRL_OFS, {28'h0, 1'b1, sr, t}, r);
      chk(r, `IPS_RESP_OKAY);
      @(negedge core_clk);
      if (t != 2'h3) eterm = t;
      chk({global_output_tristate, global_write_enable}, 2'h1);
      chk({unused_pullup_en, unused_pulldown_en}, pulls(eterm));
      chk(io_reg_level, sr);
      chk(global_set_reset, 1'b0);
      chk({select_pin_gpio_en, io_pullup_en}, 2'h2);
      axr(`IPS_STAT_OFS, d, r);
      chk(d[7:0], {seed[2:0], 5'h10});
      bscan_highz_active <= 1'b1;
      repeat (9) @(negedge core_clk);
      chk({io_pulldown_en, io_pullup_en}, 2'h2);
      @(posedge core_clk);
      bscan_highz_active <= 1'b0;
      pwr_en <= 3'h7 ^ (3'h1 << it);
      repeat (9) @(negedge core_clk);
      chk({global_output_tristate, global_write_enable, init_complete}, 3'h4);
      @(posedge core_clk);
      pwr_en <= 3'h0;
    end
    axw(8'h40, 32'hF, r);
    chk(r, `IPS_RESP_SLVERR);
    axr(8'h40, d, r);
    chk(d, 32'h0);
    chk(r, `IPS_RESP_SLVERR);
    complete_run();
  end
endmodule
